// ==== common/mcp_pkg.sv ====
/*
 * Constants for the master clock and divider mode select block.
 * Assumes a single 50 MHz system clock and a plain register port.
 */
package mcp_pkg;

	// ------------------------------------------------------------
	// System clock
	// ------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 50_000_000;

	// ------------------------------------------------------------
	// Divider select codes and their divide ratios
	// ------------------------------------------------------------
	localparam logic [2:0] DIV_CODE_1 = 3'h0;
	localparam logic [2:0] DIV_CODE_2 = 3'h1;
	localparam logic [2:0] DIV_CODE_4 = 3'h2;
	localparam logic [2:0] DIV_CODE_6 = 3'h3;
	localparam logic [2:0] DIV_CODE_8 = 3'h4;
	localparam logic [3:0] DIV_RATIO_1 = 4'h1;
	localparam logic [3:0] DIV_RATIO_2 = 4'h2;
	localparam logic [3:0] DIV_RATIO_4 = 4'h4;
	localparam logic [3:0] DIV_RATIO_6 = 4'h6;
	localparam logic [3:0] DIV_RATIO_8 = 4'h8;

	// ------------------------------------------------------------
	// Core clock arithmetic
	// ------------------------------------------------------------
	localparam logic [11:0] CORE_MULT         = 12'h038;
	localparam logic [11:0] INSTR_PER_NORMAL  = 12'he00;
	localparam logic [11:0] INSTR_PER_DUAL    = 12'h700;
	localparam logic [11:0] INSTR_PER_QUAD    = 12'h380;
	localparam int unsigned INIT_PERIODS      = 32768;

	// ------------------------------------------------------------
	// Core rate modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MCP_RATE_NORMAL = 2'h0,
		MCP_RATE_DUAL   = 2'h1,
		MCP_RATE_QUAD   = 2'h2
	} mcp_rate_t;

	// ------------------------------------------------------------
	// Clock output modes; toggles per 64x reference period
	// ------------------------------------------------------------
	localparam logic [1:0] CLOCK_OUTPUT_PIN_OFF  = 2'h0;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_OSC  = 2'h1;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_256  = 2'h2;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_512  = 2'h3;
	localparam logic [4:0] TOGGLES_256 = 5'h08;
	localparam logic [4:0] TOGGLES_512 = 5'h10;
	localparam logic [5:0] TOGGLE_MAX  = 6'h3f;

	// ------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ------------------------------------------------------------
	localparam logic [7:0] REG_RATE_CTRL   = 8'h00;
	localparam logic [7:0] REG_CLOCK_STAT  = 8'h04;
	localparam logic [7:0] REG_SAMPLE_CNT  = 8'h08;
	localparam logic [7:0] REG_CORE_PHASE  = 8'h0c;
	localparam int unsigned STAT_INIT_DONE = 0;
	localparam int unsigned STAT_DIV_LSB   = 1;
	localparam int unsigned STAT_BAD_DIV   = 4;
	localparam int unsigned STAT_OUT_LSB   = 5;
	localparam int unsigned STAT_REFUSED   = 7;
	localparam int unsigned STAT_MCLK_EN   = 8;

	// ------------------------------------------------------------
	// Initialization sequencer states (Gray along the path)
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MCP_ST_LATCH = 2'h0,
		MCP_ST_INIT  = 2'h1,
		MCP_ST_RUN   = 2'h3
	} mcp_state_t;

	// Settle count after release; the pin filter needs four edges to show a level
	localparam logic [2:0] SETTLE_LAST = 3'h4;

endpackage

// ==== rtl/mcp_pin_sync.sv ====
/*
 * Three-flop pin synchroniser with agreement filter and rise pulse.
 * Assumes inputs are asynchronous pins; outputs are on clk_i.
 */
`timescale 1ns/10ps
`default_nettype none

module mcp_pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] rise_o
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A bit only moves once the second and third stages agree
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			level_o <= '0;
			rise_o  <= '0;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					level_o[i] <= s3_q[i];
					rise_o[i]  <= s3_q[i] & ~level_o[i];
				end else begin
					rise_o[i] <= 1'b0;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== rtl/mcp_edge_divider.sv ====
/*
 * Divides a stream of input edge pulses by a loadable ratio.
 * Assumes ratio_i is held steady while enable_i is high.
 */
`timescale 1ns/10ps
`default_nettype none

module mcp_edge_divider (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       enable_i,
	input  wire logic       edge_i,
	input  wire logic [3:0] ratio_i,
	output logic            pulse_o
);

	logic [3:0] count_q;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count_q <= 4'h0;
			pulse_o <= 1'b0;
		end else if (!enable_i) begin
			count_q <= 4'h0;
			pulse_o <= 1'b0;
		end else if (edge_i) begin
			if (count_q >= ratio_i - 4'h1) begin
				count_q <= 4'h0;
				pulse_o <= 1'b1;
			end else begin
				count_q <= count_q + 4'h1;
				pulse_o <= 1'b0;
			end
		end else begin
			pulse_o <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ==== rtl/mcp_master_clock.sv ====
/*
 * Master clock divider, core clock model, init sequencer and clock
 * output selector. Assumes the crystal input and all mode pins are
 * asynchronous, and a plain register port on clk_i.
 */
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

module mcp_master_clock #(
	parameter int unsigned INIT_COUNT = mcp_pkg::INIT_PERIODS
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        crystal_input_pin_i,
	input  wire logic        divider_select_bit0_i,
	input  wire logic        divider_select_bit1_i,
	input  wire logic        divider_select_bit2_i,
	input  wire logic        clock_output_sel_bit0_i,
	input  wire logic        clock_output_sel_bit1_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_write_i,
	input  wire logic        reg_read_i,
	output logic      [31:0] reg_rdata_o,
	output logic             clock_output_pin_o,
	output logic             clock_output_pin_oe_o,
	output logic             ref_pulse_o,
	output logic             sample_start_o,
	output logic             mclk_enable_o,
	output logic             init_done_o
);

	// ------------------------------------------------------------
	// Local helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] div_ratio(input logic [2:0] code);
		logic [3:0] r;
		r = mcp_pkg::DIV_RATIO_1;
		case (code)
			mcp_pkg::DIV_CODE_1: r = mcp_pkg::DIV_RATIO_1;
			mcp_pkg::DIV_CODE_2: r = mcp_pkg::DIV_RATIO_2;
			mcp_pkg::DIV_CODE_4: r = mcp_pkg::DIV_RATIO_4;
			mcp_pkg::DIV_CODE_6: r = mcp_pkg::DIV_RATIO_6;
			mcp_pkg::DIV_CODE_8: r = mcp_pkg::DIV_RATIO_8;
			default:             r = mcp_pkg::DIV_RATIO_1;
		endcase
		return r;
	endfunction

	function automatic logic [11:0] instr_per_sample(input logic [1:0] mode);
		logic [11:0] n;
		n = mcp_pkg::INSTR_PER_NORMAL;
		case (mode)
			mcp_pkg::MCP_RATE_DUAL: n = mcp_pkg::INSTR_PER_DUAL;
			mcp_pkg::MCP_RATE_QUAD: n = mcp_pkg::INSTR_PER_QUAD;
			default:                n = mcp_pkg::INSTR_PER_NORMAL;
		endcase
		return n;
	endfunction

	localparam logic [15:0] INIT_LAST = 16'(INIT_COUNT - 1);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [5:0] pins_raw;
	logic [5:0] pins_level;
	logic [5:0] pins_rise;

	assign pins_raw = {clock_output_sel_bit1_i, clock_output_sel_bit0_i,
	                   divider_select_bit2_i, divider_select_bit1_i,
	                   divider_select_bit0_i, crystal_input_pin_i};

	mcp_pin_sync #(
		.WIDTH (6)
	) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   (pins_raw),
		.level_o (pins_level),
		.rise_o  (pins_rise)
	);

	logic       xtal_level;
	logic       xtal_rise;
	logic [1:0] out_sel;

	assign xtal_level = pins_level[0];
	assign xtal_rise  = pins_rise[0];
	assign out_sel    = pins_level[5:4];

	// ------------------------------------------------------------
	// Initialization sequencer
	// ------------------------------------------------------------
	mcp_pkg::mcp_state_t state_q;
	logic [2:0]          div_code_q;
	logic [3:0]          div_ratio_q;
	logic                bad_div_q;
	logic [2:0]          settle_q;
	logic [15:0]         init_cnt_q;
	logic                ref_pulse;

	// Let the synchronisers fill before sampling the divider pins
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			settle_q <= 3'h0;
		end else if (state_q == mcp_pkg::MCP_ST_LATCH && settle_q != mcp_pkg::SETTLE_LAST) begin
			settle_q <= settle_q + 3'h1;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= mcp_pkg::MCP_ST_LATCH;
		end else begin
			case (state_q)
				mcp_pkg::MCP_ST_LATCH: begin
					if (settle_q == mcp_pkg::SETTLE_LAST) begin
						state_q <= mcp_pkg::MCP_ST_INIT;
					end
				end
				mcp_pkg::MCP_ST_INIT: begin
					if (ref_pulse && init_cnt_q == INIT_LAST) begin
						state_q <= mcp_pkg::MCP_ST_RUN;
					end
				end
				mcp_pkg::MCP_ST_RUN: begin
					state_q <= mcp_pkg::MCP_ST_RUN;
				end
				default: begin
					state_q <= mcp_pkg::MCP_ST_LATCH;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_code_q  <= mcp_pkg::DIV_CODE_1;
			div_ratio_q <= mcp_pkg::DIV_RATIO_1;
			bad_div_q   <= 1'b0;
		end else if (state_q == mcp_pkg::MCP_ST_LATCH && settle_q == mcp_pkg::SETTLE_LAST) begin
			div_code_q  <= pins_level[3:1];
			div_ratio_q <= div_ratio(pins_level[3:1]);
			bad_div_q   <= pins_level[3:1] > mcp_pkg::DIV_CODE_8;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			init_cnt_q <= 16'h0000;
		end else if (state_q == mcp_pkg::MCP_ST_INIT && ref_pulse) begin
			init_cnt_q <= init_cnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// Reference divider: crystal edges to 64x fs
	// ------------------------------------------------------------
	logic div_enable;

	assign div_enable = state_q != mcp_pkg::MCP_ST_LATCH;

	mcp_edge_divider u_div (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.enable_i (div_enable),
		.edge_i   (xtal_rise),
		.ratio_i  (div_ratio_q),
		.pulse_o  (ref_pulse)
	);

	// ------------------------------------------------------------
	// Core clock model and sample start
	// ------------------------------------------------------------
	logic [1:0]  rate_q;
	logic [11:0] core_phase_q;
	logic [11:0] phase_sum;
	logic [11:0] phase_limit;
	logic [15:0] sample_cnt_q;
	logic        running;

	assign running     = state_q == mcp_pkg::MCP_ST_RUN;
	assign phase_limit = instr_per_sample(rate_q);
	assign phase_sum   = core_phase_q + mcp_pkg::CORE_MULT;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			core_phase_q   <= 12'h000;
			sample_start_o <= 1'b0;
			sample_cnt_q   <= 16'h0000;
		end else if (running && ref_pulse) begin
			if (phase_sum >= phase_limit) begin
				core_phase_q   <= phase_sum - phase_limit;
				sample_start_o <= 1'b1;
				sample_cnt_q   <= sample_cnt_q + 16'h0001;
			end else begin
				core_phase_q   <= phase_sum;
				sample_start_o <= 1'b0;
			end
		end else begin
			sample_start_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mclk_enable_o <= 1'b0;
			init_done_o   <= 1'b0;
			ref_pulse_o   <= 1'b0;
		end else begin
			mclk_enable_o <= running;
			init_done_o   <= running;
			ref_pulse_o   <= ref_pulse & running;
		end
	end

	// ------------------------------------------------------------
	// Clock output pin
	// ------------------------------------------------------------
	// Fast modes emit their toggle count in a burst per reference period
	logic [5:0] toggles_q;
	logic [4:0] toggle_add;
	logic [6:0] toggle_sum;

	always_comb begin
		toggle_add = 5'h00;
		if (out_sel == mcp_pkg::CLOCK_OUTPUT_PIN_256) begin
			toggle_add = mcp_pkg::TOGGLES_256;
		end else if (out_sel == mcp_pkg::CLOCK_OUTPUT_PIN_512) begin
			toggle_add = mcp_pkg::TOGGLES_512;
		end
	end

	always_comb begin
		toggle_sum = {1'b0, toggles_q};
		if (ref_pulse) begin
			toggle_sum = toggle_sum + {2'h0, toggle_add};
		end
		if (toggle_sum != 7'h00) begin
			toggle_sum = toggle_sum - 7'h01;
		end
	end

	logic fast_clk_q;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			toggles_q  <= 6'h00;
			fast_clk_q <= 1'b0;
		end else begin
			if (toggle_sum > {1'b0, mcp_pkg::TOGGLE_MAX}) begin
				toggles_q <= mcp_pkg::TOGGLE_MAX;
			end else begin
				toggles_q <= toggle_sum[5:0];
			end
			if (toggles_q != 6'h00 || ref_pulse) begin
				fast_clk_q <= ~fast_clk_q;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			clock_output_pin_o    <= 1'b0;
			clock_output_pin_oe_o <= 1'b0;
		end else begin
			case (out_sel)
				mcp_pkg::CLOCK_OUTPUT_PIN_OFF: begin
					clock_output_pin_o    <= 1'b0;
					clock_output_pin_oe_o <= 1'b0;
				end
				mcp_pkg::CLOCK_OUTPUT_PIN_OSC: begin
					clock_output_pin_o    <= xtal_level;
					clock_output_pin_oe_o <= 1'b1;
				end
				default: begin
					clock_output_pin_o    <= fast_clk_q & div_enable;
					clock_output_pin_oe_o <= 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	logic refused_q;
	logic wr_refused;
	logic stat_read;

	assign wr_refused = reg_write_i && !running;
	assign stat_read  = reg_read_i && reg_addr_i == mcp_pkg::REG_CLOCK_STAT;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rate_q <= mcp_pkg::MCP_RATE_NORMAL;
		end else if (reg_write_i && running && reg_addr_i == mcp_pkg::REG_RATE_CTRL) begin
			if (reg_wdata_i[1:0] != 2'h3) begin
				rate_q <= reg_wdata_i[1:0];
			end
		end
	end

	// Sticky refusal flag; a new refusal beats the clear by read
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			refused_q <= 1'b0;
		end else if (wr_refused) begin
			refused_q <= 1'b1;
		end else if (stat_read) begin
			refused_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			reg_rdata_o <= 32'h0000_0000;
			if (reg_read_i) begin
				if (reg_addr_i == mcp_pkg::REG_RATE_CTRL) begin
					reg_rdata_o[1:0] <= rate_q;
				end else if (reg_addr_i == mcp_pkg::REG_CLOCK_STAT) begin
					reg_rdata_o[mcp_pkg::STAT_INIT_DONE]                      <= running;
					reg_rdata_o[mcp_pkg::STAT_DIV_LSB +: 3]                   <= div_code_q;
					reg_rdata_o[mcp_pkg::STAT_BAD_DIV]                        <= bad_div_q;
					reg_rdata_o[mcp_pkg::STAT_OUT_LSB +: 2]                   <= out_sel;
					reg_rdata_o[mcp_pkg::STAT_REFUSED]                        <= refused_q;
					reg_rdata_o[mcp_pkg::STAT_MCLK_EN]                        <= mclk_enable_o;
				end else if (reg_addr_i == mcp_pkg::REG_SAMPLE_CNT) begin
					reg_rdata_o[15:0] <= sample_cnt_q;
				end else if (reg_addr_i == mcp_pkg::REG_CORE_PHASE) begin
					reg_rdata_o[11:0] <= core_phase_q;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== verif/mcp_master_clock_asserts.sv ====
/* Port checker for mcp_master_clock, bound at the foot.
   Assumes divider pins are steady while reset is held. */
`timescale 1ns/10ps
`default_nettype none
module mcp_chk #(
	parameter int unsigned INIT_COUNT = 4
) (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        crystal_input_pin_i,
	input wire logic        divider_select_bit0_i,
	input wire logic        divider_select_bit1_i,
	input wire logic        divider_select_bit2_i,
	input wire logic        clock_output_sel_bit0_i,
	input wire logic        clock_output_sel_bit1_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_read_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        clock_output_pin_o,
	input wire logic        clock_output_pin_oe_o,
	input wire logic        ref_pulse_o,
	input wire logic        sample_start_o,
	input wire logic        mclk_enable_o,
	input wire logic        init_done_o
);
	// ------------------------------------------------------------
	// Crystal edge counts
	// ------------------------------------------------------------
	logic [2:0] code_q;
	logic [3:0] div;
	logic [7:0] ecnt_q;
	logic [7:0] icnt_q;
	logic       xt_q;
	logic       seen_q;
	wire logic  rise = crystal_input_pin_i & ~xt_q;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			code_q <= {divider_select_bit2_i, divider_select_bit1_i, divider_select_bit0_i};
		end
	end

	always_comb begin
		case (code_q)
			mcp_pkg::DIV_CODE_2: div = mcp_pkg::DIV_RATIO_2;
			mcp_pkg::DIV_CODE_4: div = mcp_pkg::DIV_RATIO_4;
			mcp_pkg::DIV_CODE_6: div = mcp_pkg::DIV_RATIO_6;
			mcp_pkg::DIV_CODE_8: div = mcp_pkg::DIV_RATIO_8;
			default: div = mcp_pkg::DIV_RATIO_1;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			xt_q   <= 1'b0;
			seen_q <= 1'b0;
			ecnt_q <= 8'h00;
			icnt_q <= 8'h00;
		end else begin
			xt_q   <= crystal_input_pin_i;
			seen_q <= seen_q | ref_pulse_o;
			ecnt_q <= ref_pulse_o ? 8'h00 : ecnt_q + {7'h00, rise};
			if (!init_done_o) begin
				icnt_q <= icnt_q + {7'h00, rise};
			end
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_off;
		(!clock_output_sel_bit1_i && !clock_output_sel_bit0_i) [*8];
	endsequence
	sequence s_on;
		(clock_output_sel_bit1_i || clock_output_sel_bit0_i) [*8];
	endsequence

	rd_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside its slot");
	stat_bits_a: assert property ($past(reg_read_i && reg_addr_i == mcp_pkg::REG_CLOCK_STAT) |->
		reg_rdata_o[mcp_pkg::STAT_MCLK_EN] == reg_rdata_o[mcp_pkg::STAT_INIT_DONE] && reg_rdata_o[3:1] == code_q)
		else $error("status bits wrong");
	done_en_a: assert property (init_done_o == mclk_enable_o)
		else $error("done and clock enable differ");
	done_hold_a: assert property (init_done_o |=> init_done_o)
		else $error("done dropped");
	init_len_a: assert property ($rose(init_done_o) |-> int'(icnt_q) >= INIT_COUNT * div &&
		int'(icnt_q) <= INIT_COUNT * div + 3)
		else $error("init length wrong");
	ref_gap_a: assert property (ref_pulse_o && seen_q |-> (ecnt_q + {7'h00, rise}) == {4'h0, div})
		else $error("reference spacing wrong");
	ref_run_a: assert property (ref_pulse_o |-> init_done_o ##1 !ref_pulse_o)
		else $error("reference pulse misplaced");
	smp_ref_a: assert property (sample_start_o |-> init_done_o && (ref_pulse_o || $past(ref_pulse_o)))
		else $error("sample start without reference");
	out_off_a: assert property (s_off |-> !clock_output_pin_oe_o && !clock_output_pin_o)
		else $error("clock output not off");
	out_on_a: assert property (s_on |-> clock_output_pin_oe_o)
		else $error("clock output not driven");
endmodule

bind mcp_master_clock mcp_chk #(
	.INIT_COUNT(INIT_COUNT)
) i_chk (
	.clk_i                  (clk_i),
	.reset_i                (reset_i),
	.crystal_input_pin_i    (crystal_input_pin_i),
	.divider_select_bit0_i  (divider_select_bit0_i),
	.divider_select_bit1_i  (divider_select_bit1_i),
	.divider_select_bit2_i  (divider_select_bit2_i),
	.clock_output_sel_bit0_i(clock_output_sel_bit0_i),
	.clock_output_sel_bit1_i(clock_output_sel_bit1_i),
	.reg_addr_i             (reg_addr_i),
	.reg_read_i             (reg_read_i),
	.reg_rdata_o            (reg_rdata_o),
	.clock_output_pin_o     (clock_output_pin_o),
	.clock_output_pin_oe_o  (clock_output_pin_oe_o),
	.ref_pulse_o            (ref_pulse_o),
	.sample_start_o         (sample_start_o),
	.mclk_enable_o          (mclk_enable_o),
	.init_done_o            (init_done_o)
);
`default_nettype wire

// ==== verif/mcp_xtal_model.sv ====
/* Crystal source model for the master clock pin.
   Assumes half_i only changes while the device is in reset. */
`timescale 1ns/10ps
`default_nettype none
module mcp_xtal_model (
	input  wire logic [3:0] half_i,
	output logic            xtal_o
);
	// Runs from power-up and never stops
	initial begin
		xtal_o = 1'b0;
		#7;
		forever begin
			#(half_i * 20);
			xtal_o = ~xtal_o;
		end
	end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
/* Self-checking bench for mcp_master_clock.
   Assumes the bound checker and the crystal source model. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk_i;
	logic        reset_i;
	logic        xtal;
	logic [3:0]  half;
	logic [2:0]  div_sel;
	logic [1:0]  out_sel;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        we;
	logic        re;
	logic [31:0] rdata;
	logic        ck_out;
	logic        ck_oe;
	logic        ref_p;
	logic        smp;
	logic        mclk;
	logic        done;
	int          bad_count;
	int          n_tests;
	int          cyc;
	int          t0;
	int          dr[8]  = '{1, 2, 4, 6, 8, 1, 1, 1};
	int          ipr[3] = '{3584, 1792, 896};
	int          tg[4]  = '{0, 16, 8, 16};

	mcp_xtal_model i_mcp_xtal_model (.half_i(half), .xtal_o(xtal));

	mcp_master_clock #(
		.INIT_COUNT(4)
	) i_mcp_master_clock (
		.clk_i                  (clk_i),
		.reset_i                (reset_i),
		.crystal_input_pin_i    (xtal),
		.divider_select_bit0_i  (div_sel[0]),
		.divider_select_bit1_i  (div_sel[1]),
		.divider_select_bit2_i  (div_sel[2]),
		.clock_output_sel_bit0_i(out_sel[0]),
		.clock_output_sel_bit1_i(out_sel[1]),
		.reg_addr_i             (addr),
		.reg_wdata_i            (wdata),
		.reg_write_i            (we),
		.reg_read_i             (re),
		.reg_rdata_o            (rdata),
		.clock_output_pin_o     (ck_out),
		.clock_output_pin_oe_o  (ck_oe),
		.ref_pulse_o            (ref_p),
		.sample_start_o         (smp),
		.mclk_enable_o          (mclk),
		.init_done_o            (done)
	);

	// ------------------------------------------------------------
	// Clock, cycle stamp, watchdog
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc <= cyc + 1;
	initial begin
		#400_000;
		bad_count++;
		conclude();
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr  <= a;
		wdata <= d;
		we    <= 1'b1;
		@(posedge clk_i);
		we    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk_i);
		re   <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic boot(input logic [2:0] code, input logic [3:0] h);
		@(posedge clk_i);
		reset_i <= 1'b1;
		div_sel <= code;
		half    <= h;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		t0 = cyc;
	endtask

	task automatic wait_done(input int lo, input int hi);
		int i;
		for (i = 0; i < 3000 && done !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
		chk("init span", 32'h1, 32'(cyc - t0 >= lo && cyc - t0 <= hi));
	endtask

	task automatic measure(input bit to_smp, output int n, output int refs, output int togs);
		logic p;
		p = ck_out;
		n = 0;
		refs = 0;
		togs = 0;
		while (n < 5000) begin
			@(posedge clk_i);
			#1;
			n++;
			refs += int'(ref_p === 1'b1);
			togs += int'(ck_out !== p);
			p = ck_out;
			if ((to_smp ? smp : ref_p) === 1'b1) break;
		end
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		int c;
		int h;
		int n;
		int r;
		int t;
		logic [31:0] d;
		logic [31:0] e;
		reset_i = 1'b1;
		half = 4'h4;
		div_sel = 3'h0;
		out_sel = 2'h0;
		addr = 8'h00;
		wdata = 32'h0;
		we = 1'b0;
		re = 1'b0;
		cyc = 0;
		bad_count = 0;
		n_tests = 0;
		void'($urandom(76));
		for (c = 0; c < 6; c++) begin
			h = 4 + $urandom % 3;
			boot(c[2:0], h[3:0]);
			wr(mcp_pkg::REG_RATE_CTRL, 32'h1);
			#1;
			chk("mclk held", 32'h0, {31'h0, mclk});
			wait_done((4 * dr[c] - 1) * 2 * h, 4 * dr[c] * 2 * h + 16);
			e = {23'h0, 1'b1, 1'b1, 2'h0, 1'(c > 4), c[2:0], 1'b1};
			rd(mcp_pkg::REG_CLOCK_STAT, d);
			chk("status", e, d);
			rd(mcp_pkg::REG_CLOCK_STAT, d);
			chk("status cleared", e & ~32'h80, d);
			rd(mcp_pkg::REG_RATE_CTRL, d);
			chk("rate refused", 32'h0, d);
			measure(1'b0, n, r, t);
			measure(1'b0, n, r, t);
			chk("ref gap", dr[c] * 2 * h, n);
			$display("Test divider code %0d done", c);
		end
		boot(3'h0, 4'h4);
		wait_done(24, 48);
		for (c = 0; c < 3; c++) begin
			wr(mcp_pkg::REG_RATE_CTRL, c);
			rd(mcp_pkg::REG_RATE_CTRL, d);
			chk("rate", c, d);
			measure(1'b1, n, r, t);
			measure(1'b1, n, r, t);
			chk("refs per sample", ipr[c] / 56, r);
			rd(mcp_pkg::REG_SAMPLE_CNT, e);
			rd(mcp_pkg::REG_CORE_PHASE, d);
			chk("core phase", 32'h0, d);
			measure(1'b1, n, r, t);
			rd(mcp_pkg::REG_SAMPLE_CNT, d);
			chk("sample count", e + 32'h1, d);
		end
		wr(mcp_pkg::REG_RATE_CTRL, 32'h3);
		rd(mcp_pkg::REG_RATE_CTRL, d);
		chk("rate code 3", 32'h2, d);
		wr(8'h10, $urandom);
		rd(8'h10, d);
		chk("unmapped", 32'h0, d);
		$display("Test core rates done");
		boot(3'h4, 4'h4);
		wait_done(192, 272);
		for (c = 0; c < 4; c++) begin
			@(posedge clk_i);
			out_sel <= c[1:0];
			measure(1'b0, n, r, t);
			measure(1'b0, n, r, t);
			measure(1'b0, n, r, t);
			chk("clock out toggles", tg[c], t);
			chk("clock out enable", 32'(c != 0), {31'h0, ck_oe});
		end
		$display("Test clock output done");
		conclude();
	end
endmodule
`default_nettype wire
